// ==== logic/otp_cfg_pkg.sv ====
/*
 * Constants for the one-time configuration block: register offsets,
 * field positions, reset values and status pin encodings.
 * Assumes nothing of its surroundings; imported by every design file.
 */
package otp_cfg_pkg;

    // --------------------------------------------------------------------
    // register offsets
    // --------------------------------------------------------------------
    localparam logic [7:0] major_version_number_off  = 8'h18;
    localparam logic [7:0] minor_version_number_off  = 8'h19;
    localparam logic [7:0] fifo_flush_policy_off     = 8'h1A;
    localparam logic [7:0] programmed_flags_low_off  = 8'h1D;
    localparam logic [7:0] programmed_flags_high_off = 8'h1E;
    localparam logic [7:0] status_pin_one_config_off = 8'h1F;

    // --------------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------------
    localparam logic [7:0] reg_reset_value = 8'h00;

    // --------------------------------------------------------------------
    // flush policy bits
    // --------------------------------------------------------------------
    localparam int rx_close_bit = 4;
    localparam int rx_open_bit  = 3;
    localparam int tx_close_bit = 2;
    localparam int tx_open_bit  = 1;
    localparam logic [7:0] flush_policy_mask = 8'h1E;

    // --------------------------------------------------------------------
    // programmed flags, low byte
    // --------------------------------------------------------------------
    localparam int language_code_flag         = 7;
    localparam int second_uart_pin_setup_flag = 4;
    localparam int first_uart_pin_setup_flag  = 3;
    localparam int serial_text_flag           = 2;
    localparam int product_name_part_two_flag = 1;
    localparam int product_name_part_one_flag = 0;
    localparam logic [7:0] flags_low_mask     = 8'h9F;

    // --------------------------------------------------------------------
    // programmed flags, high byte
    // --------------------------------------------------------------------
    localparam int vendor_name_part_two_flag = 7;
    localparam int vendor_name_part_one_flag = 6;
    localparam int flush_policy_flag         = 5;
    localparam int release_number_flag       = 4;
    localparam int bus_attribute_flag        = 3;
    localparam int power_budget_flag         = 2;
    localparam int product_identifier_flag   = 1;
    localparam int vendor_identifier_flag    = 0;

    // --------------------------------------------------------------------
    // status pin one configuration fields
    // --------------------------------------------------------------------
    localparam int pin_sel_lsb  = 2;
    localparam int pin_ctrl_lsb = 0;
    localparam logic [7:0] pin_cfg_mask = 8'h1F;

    localparam logic [2:0] sel_susp_or_rst_a = 3'h0;
    localparam logic [2:0] sel_susp_high     = 3'h1;
    localparam logic [2:0] sel_lowpwr_high   = 3'h2;
    localparam logic [2:0] sel_rst_high      = 3'h3;
    localparam logic [2:0] sel_susp_or_rst_b = 3'h4;
    localparam logic [2:0] sel_susp_low      = 3'h5;
    localparam logic [2:0] sel_lowpwr_low    = 3'h6;
    localparam logic [2:0] sel_rst_low       = 3'h7;

    localparam logic [1:0] ctrl_open_drain = 2'h1;
    localparam logic [1:0] ctrl_push_pull  = 2'h2;

endpackage : otp_cfg_pkg

// ==== logic/status_pin_drive.sv ====
/*
 * Drives the first status indicator pin from the bus state inputs.
 * Assumes suspend, reduced power and bus reset come from outside the
 * ref_clk domain; each passes two flip-flops before use.
 */
`timescale 1ns/1ps
`default_nettype none

module status_pin_drive (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire logic                     suspend_in,
    input  wire logic                     reduced_power_state,
    input  wire logic                     bus_reset_in,
    input  wire logic [2:0]               pin_sel,
    input  wire logic [1:0]               pin_ctrl,
    output logic                          pin_out,
    output logic                          pin_oe_n
);
    import otp_cfg_pkg::*;

    logic [2:0] sync1;
    logic [2:0] sync2;
    logic       level;
    logic       next_pin_out;
    logic       next_pin_oe_n;

    // --------------------------------------------------------------------
    // two-stage synchroniser: suspend, reduced power, bus reset
    // --------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
        end else begin
            sync1 <= {bus_reset_in, reduced_power_state, suspend_in};
            sync2 <= sync1;
        end
    end

    // pin level per selected condition
    always_comb begin
        case (pin_sel)
            sel_susp_or_rst_a: level = sync2[0] | sync2[2];
            sel_susp_high:     level = sync2[0];
            sel_lowpwr_high:   level = sync2[1];
            sel_rst_high:      level = sync2[2];
            sel_susp_or_rst_b: level = sync2[0] | sync2[2];
            sel_susp_low:      level = ~sync2[0];
            sel_lowpwr_low:    level = ~sync2[1];
            sel_rst_low:       level = ~sync2[2];
            default:           level = 1'b0;
        endcase
    end

    // output driver type; invalid codes leave the pin undriven
    always_comb begin
        case (pin_ctrl)
            ctrl_open_drain: begin
                next_pin_out  = 1'b0;
                next_pin_oe_n = level;
            end
            ctrl_push_pull: begin
                next_pin_out  = level;
                next_pin_oe_n = 1'b0;
            end
            default: begin
                next_pin_out  = 1'b0;
                next_pin_oe_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out  <= 1'b0;
            pin_oe_n <= 1'b1;
        end else begin
            pin_out  <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
        end
    end

    // --------------------------------------------------------------------
    // checks
    // --------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_susp_high_pp: assert property (
        ($past(pin_sel) == sel_susp_high && $past(pin_ctrl) == ctrl_push_pull
         && $past(rst_n, 3))
        |-> (pin_out == $past(suspend_in, 3)) && !pin_oe_n)
        else $error("status pin does not follow suspend");

    a_rst_low_pp: assert property (
        ($past(pin_sel) == sel_rst_low && $past(pin_ctrl) == ctrl_push_pull
         && $past(rst_n, 3))
        |-> pin_out == !$past(bus_reset_in, 3))
        else $error("status pin not low during bus reset");

    a_open_drain: assert property (
        ($past(pin_ctrl) == ctrl_open_drain && $past(pin_sel) == sel_lowpwr_high
         && $past(rst_n, 3))
        |-> !pin_out && (pin_oe_n == $past(reduced_power_state, 3)))
        else $error("open drain pin drives high");

    a_invalid_ctrl: assert property (
        ($past(pin_ctrl) != ctrl_open_drain && $past(pin_ctrl) != ctrl_push_pull)
        |-> pin_oe_n)
        else $error("pin driven under invalid drive type");

endmodule : status_pin_drive

`default_nettype wire

// ==== logic/otp_config_flush_status_pin.sv ====
/*
 * One-time configuration registers: release numbers, fifo flush policy,
 * programmed flags and first status pin setup, with flush pulses on
 * serial port open and close.
 * Assumes the register port and the open/close events come from logic on
 * ref_clk, and that the fifos reset their pointers on the flush pulses.
 */
// What this block does
// - flush policy bit 4 set: flush receive fifo when port closes.
// - flush policy bit 3 set: flush receive fifo when port opens.
// - flush policy bit 2 set: flush transmit fifo when port closes.
// - flush policy bit 1 set: flush transmit fifo when port opens.
// - release and flush policy values are used only when their programmed flag is one.
// - release number and flush policy fields refuse further writes once their programmed flag is set.
// - low flag byte: 7 language, 4/3 uart pins, 2 serial, 1/0 product.
// - high flag byte: 7/6 vendor, 5 flush, 4 release, 3..0 bus fields.
// - select codes 000..100 drive pin high during chosen condition.
// - select codes 101..111 drive pin low during chosen condition.
// - drive type 01 open drain, 10 push-pull; 00 and 11 invalid.
// - status pin settings govern pin behaviour while suspended.
`timescale 1ns/1ps
`default_nettype none

module otp_config_flush_status_pin (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [7:0]                    reg_rdata,
    output logic                          reg_rvalid,
    output logic                          write_refused,
    input  wire logic                     port_open,
    input  wire logic                     port_close,
    output logic                          rx_flush,
    output logic                          tx_flush,
    output logic [7:0]                    major_release,
    output logic [7:0]                    minor_release,
    output logic [15:0]                   field_used,
    input  wire logic                     suspend_in,
    input  wire logic                     reduced_power_state,
    input  wire logic                     bus_reset_in,
    output logic                          status_indicator_pin_one_out,
    output logic                          status_indicator_pin_one_oe_n
);
    import otp_cfg_pkg::*;

    logic [7:0] major_version_number;
    logic [7:0] minor_version_number;
    logic [7:0] fifo_flush_policy;
    logic [7:0] programmed_flags_low;
    logic [7:0] programmed_flags_high;
    logic [7:0] status_pin_one_config;
    logic [7:0] next_major_version_number;
    logic [7:0] next_minor_version_number;
    logic [7:0] next_fifo_flush_policy;
    logic [7:0] next_programmed_flags_low;
    logic [7:0] next_programmed_flags_high;
    logic [7:0] next_status_pin_one_config;
    logic       next_write_refused;
    logic [7:0] next_reg_rdata;
    logic       next_reg_rvalid;
    logic       next_rx_flush;
    logic       next_tx_flush;
    logic [7:0] flush_in_use;

    // write is refused when the addressed field is already burnt
    function automatic logic field_locked(input logic [7:0] addr,
                                          input logic [7:0] flags_high);
        case (addr)
            major_version_number_off,
            minor_version_number_off: field_locked = flags_high[release_number_flag];
            fifo_flush_policy_off:    field_locked = flags_high[flush_policy_flag];
            default:                  field_locked = 1'b0;
        endcase
    endfunction : field_locked

    // --------------------------------------------------------------------
    // register writes
    // --------------------------------------------------------------------
    always_comb begin
        next_major_version_number  = major_version_number;
        next_minor_version_number  = minor_version_number;
        next_fifo_flush_policy     = fifo_flush_policy;
        next_programmed_flags_low  = programmed_flags_low;
        next_programmed_flags_high = programmed_flags_high;
        next_status_pin_one_config = status_pin_one_config;
        next_write_refused         = 1'b0;
        if (reg_wr) begin
            if (field_locked(reg_addr, programmed_flags_high)) begin
                next_write_refused = 1'b1;
            end else begin
                case (reg_addr)
                    major_version_number_off:
                        next_major_version_number = reg_wdata;
                    minor_version_number_off:
                        next_minor_version_number = reg_wdata;
                    fifo_flush_policy_off:
                        next_fifo_flush_policy = reg_wdata & flush_policy_mask;
                    // flags only ever gain bits: a set flag stays set
                    programmed_flags_low_off:
                        next_programmed_flags_low = programmed_flags_low
                            | (reg_wdata & flags_low_mask);
                    programmed_flags_high_off:
                        next_programmed_flags_high = programmed_flags_high
                            | reg_wdata;
                    status_pin_one_config_off:
                        next_status_pin_one_config = reg_wdata & pin_cfg_mask;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            major_version_number  <= reg_reset_value;
            minor_version_number  <= reg_reset_value;
            fifo_flush_policy     <= reg_reset_value;
            programmed_flags_low  <= reg_reset_value;
            programmed_flags_high <= reg_reset_value;
            status_pin_one_config <= reg_reset_value;
            write_refused         <= 1'b0;
        end else begin
            major_version_number  <= next_major_version_number;
            minor_version_number  <= next_minor_version_number;
            fifo_flush_policy     <= next_fifo_flush_policy;
            programmed_flags_low  <= next_programmed_flags_low;
            programmed_flags_high <= next_programmed_flags_high;
            status_pin_one_config <= next_status_pin_one_config;
            write_refused         <= next_write_refused;
        end
    end

    // --------------------------------------------------------------------
    // register reads and values in use
    // --------------------------------------------------------------------
    always_comb begin
        next_reg_rvalid = reg_rd;
        next_reg_rdata  = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                major_version_number_off:  next_reg_rdata = major_version_number;
                minor_version_number_off:  next_reg_rdata = minor_version_number;
                fifo_flush_policy_off:     next_reg_rdata = fifo_flush_policy;
                programmed_flags_low_off:  next_reg_rdata = programmed_flags_low;
                programmed_flags_high_off: next_reg_rdata = programmed_flags_high;
                status_pin_one_config_off: next_reg_rdata = status_pin_one_config;
                default:                   next_reg_rdata = 8'h00;
            endcase
        end
    end

    // stored values are ignored until their flag is burnt
    assign flush_in_use  = programmed_flags_high[flush_policy_flag]
                           ? fifo_flush_policy : 8'h00;
    assign major_release = programmed_flags_high[release_number_flag]
                           ? major_version_number : 8'h00;
    assign minor_release = programmed_flags_high[release_number_flag]
                           ? minor_version_number : 8'h00;
    assign field_used    = {programmed_flags_high, programmed_flags_low};

    // --------------------------------------------------------------------
    // flush pulses on port open and close
    // --------------------------------------------------------------------
    always_comb begin
        next_rx_flush = (port_close & flush_in_use[rx_close_bit])
                      | (port_open  & flush_in_use[rx_open_bit]);
        next_tx_flush = (port_close & flush_in_use[tx_close_bit])
                      | (port_open  & flush_in_use[tx_open_bit]);
    end

    // one-cycle pulses; the fifo clears pointers on them
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
            rx_flush   <= 1'b0;
            tx_flush   <= 1'b0;
        end else begin
            reg_rdata  <= next_reg_rdata;
            reg_rvalid <= next_reg_rvalid;
            rx_flush   <= next_rx_flush;
            tx_flush   <= next_tx_flush;
        end
    end

    // status pin one driver
    status_pin_drive u_status_pin_drive (
        .ref_clk             (ref_clk),
        .rst_n               (rst_n),
        .suspend_in          (suspend_in),
        .reduced_power_state (reduced_power_state),
        .bus_reset_in        (bus_reset_in),
        .pin_sel             (status_pin_one_config[pin_sel_lsb +: 3]),
        .pin_ctrl            (status_pin_one_config[pin_ctrl_lsb +: 2]),
        .pin_out             (status_indicator_pin_one_out),
        .pin_oe_n            (status_indicator_pin_one_oe_n)
    );

    // --------------------------------------------------------------------
    // checks
    // --------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence close_with(int b);
        port_close && flush_in_use[b];
    endsequence

    sequence open_with(int b);
        port_open && flush_in_use[b];
    endsequence

    a_rx_close_flush: assert property (close_with(rx_close_bit) |=> rx_flush)
        else $error("rx fifo not flushed on close");

    a_rx_open_flush: assert property (open_with(rx_open_bit) |=> rx_flush)
        else $error("rx fifo not flushed on open");

    a_tx_close_flush: assert property (close_with(tx_close_bit) |=> tx_flush)
        else $error("tx fifo not flushed on close");

    a_tx_open_flush: assert property (open_with(tx_open_bit) |=> tx_flush)
        else $error("tx fifo not flushed on open");

    a_unburnt_policy: assert property (
        !programmed_flags_high[flush_policy_flag] |=> !rx_flush && !tx_flush)
        else $error("flush taken from unburnt policy");

    a_write_once: assert property (
        reg_wr && reg_addr == major_version_number_off
        && programmed_flags_high[release_number_flag]
        |=> $stable(major_version_number) && write_refused)
        else $error("burnt field accepted a second write");

    a_flags_sticky: assert property (
        1'b1 |=> ((field_used & $past(field_used)) == $past(field_used)))
        else $error("programmed flag was cleared");

    a_no_open_flush: assert property (
        port_open && !port_close && !flush_in_use[rx_open_bit]
        && !flush_in_use[tx_open_bit] |=> !rx_flush && !tx_flush)
        else $error("flush on open without policy");

endmodule : otp_config_flush_status_pin

`default_nettype wire

// ==== sim/host_config_model.sv ====
/*
 * Host side model: byte writes and reads on the register port.
 * Assumes the bench calls its tasks and that all share ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module host_config_model (
    input  wire logic       ref_clk,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    // idle port at time zero
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;

    // one write strobe; callers enter whole fields before their flag
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;  // released lines never keep the last value
        reg_wdata <= ~d;
    endtask : write

    // one read strobe, then a bounded wait for the answer
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d  = 'x;
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge ref_clk);
            if (reg_rvalid === 1'b1) begin
                d  = reg_rdata;
                ok = 1'b1;
            end
        end
    endtask : read
endmodule : host_config_model

`default_nettype wire

// ==== sim/otp_config_flush_status_pin_test.sv ====
/*
 * Self-checking bench for the one-time configuration block.
 * Assumes the host model drives the register port; bench drives the rest.
 */
`timescale 1ns/1ps
`default_nettype none

module otp_config_flush_status_pin_test;
    import otp_cfg_pkg::*;
    logic        ref_clk, rst_n, reg_wr, reg_rd, reg_rvalid, write_refused;
    logic        port_open, port_close, rx_flush, tx_flush;
    logic        suspend_in, reduced_power_state, bus_reset_in, pin_out, pin_oe_n;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, major_release, minor_release;
    logic [15:0] field_used;
    int          errors, checks_done;

    otp_config_flush_status_pin u_otp_config_flush_status_pin (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .write_refused(write_refused), .port_open(port_open), .port_close(port_close),
        .rx_flush(rx_flush), .tx_flush(tx_flush), .major_release(major_release),
        .minor_release(minor_release), .field_used(field_used), .suspend_in(suspend_in),
        .reduced_power_state(reduced_power_state), .bus_reset_in(bus_reset_in),
        .status_indicator_pin_one_out(pin_out), .status_indicator_pin_one_oe_n(pin_oe_n));

    host_config_model u_host_config_model (
        .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    // 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic end_sim;
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // read and compare; a lost answer ends the run
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        u_host_config_model.read(a, d, ok);
        chk("read data", {8'h00, d}, {8'h00, exp});
        if (ok !== 1'b1) begin
            errors++;
            end_sim();
        end
    endtask : rchk

    task automatic wchk(input logic [7:0] a, input logic [7:0] d, input logic refused);
        u_host_config_model.write(a, d);
        #1;
        chk("write refused", {15'h0, write_refused}, {15'h0, refused});
    endtask : wchk

    // one open/close event, flush pulses seen one cycle later
    task automatic ev(input logic op, input logic cl, input logic erx, input logic etx);
        @(posedge ref_clk);
        port_open  <= op;
        port_close <= cl;
        @(posedge ref_clk);
        port_open  <= 1'b0;
        port_close <= 1'b0;
        #1;
        chk("rx flush", {15'h0, rx_flush}, {15'h0, erx});
        chk("tx flush", {15'h0, tx_flush}, {15'h0, etx});
    endtask : ev

    function automatic logic level(input logic [2:0] sel, input logic [2:0] c);
        case (sel)
            3'h1: return c[2];
            3'h2: return c[1];
            3'h3: return c[0];
            3'h5: return !c[2];
            3'h6: return !c[1];
            3'h7: return !c[0];
            default: return c[2] | c[0];
        endcase
    endfunction : level

    // set pin config and bus state {suspend, reduced power, bus reset}
    task automatic pin(input logic [2:0] sel, input logic [1:0] ctl, input logic [2:0] c,
                       input logic eout, input logic eoe);
        u_host_config_model.write(8'h1F, {3'h7, sel, ctl});
        {suspend_in, reduced_power_state, bus_reset_in} <= c;
        repeat (4) @(posedge ref_clk);
        #1;
        chk("pin out", {15'h0, pin_out}, {15'h0, eout});
        chk("pin oe_n", {15'h0, pin_oe_n}, {15'h0, eoe});
    endtask : pin

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask : do_reset

    // main sequence
    initial begin
        errors = 0;
        checks_done = 0;
        {rst_n, port_open, port_close, suspend_in, reduced_power_state, bus_reset_in} = '0;
        do_reset();
        #1 chk("oe_n after reset", {15'h0, pin_oe_n}, 16'h0001);
        for (int a = 8'h18; a <= 8'h1F; a++) rchk(8'(a), 8'h00);
        wchk(8'h18, 8'hA5, 1'b0);
        wchk(8'h19, 8'h3C, 1'b0);
        chk("major unused", {8'h00, major_release}, 16'h0000);
        wchk(8'h1E, 8'h10, 1'b0);
        chk("major used", {8'h00, major_release}, 16'h00A5);
        chk("minor used", {8'h00, minor_release}, 16'h003C);
        wchk(8'h18, 8'h11, 1'b1);
        rchk(8'h18, 8'hA5);
        wchk(8'h1A, 8'hFF, 1'b0);
        rchk(8'h1A, 8'h1E);
        ev(1'b1, 1'b1, 1'b0, 1'b0);
        ev(1'b1, 1'b0, 1'b0, 1'b0);
        wchk(8'h1A, 8'h12, 1'b0);
        wchk(8'h1E, 8'h20, 1'b0);
        rchk(8'h1E, 8'h30);
        ev(1'b0, 1'b1, 1'b1, 1'b0);
        ev(1'b1, 1'b0, 1'b0, 1'b1);
        wchk(8'h1A, 8'h0C, 1'b1);
        do_reset();
        wchk(8'h1A, 8'h0C, 1'b0);
        wchk(8'h1E, 8'h20, 1'b0);
        ev(1'b0, 1'b1, 1'b0, 1'b1);
        ev(1'b1, 1'b0, 1'b1, 1'b0);
        wchk(8'h1D, 8'hFF, 1'b0);
        wchk(8'h1D, 8'h00, 1'b0);
        rchk(8'h1D, 8'h9F);
        chk("field used", field_used, 16'h209F);
        for (int s = 0; s < 8; s++) begin
            for (int c = 0; c < 5; c = (c == 0) ? 1 : c * 2) begin
                pin(3'(s), 2'h2, 3'(c), level(3'(s), 3'(c)), 1'b0);
            end
        end
        pin(3'h1, 2'h1, 3'h4, 1'b0, 1'b1);
        pin(3'h1, 2'h1, 3'h0, 1'b0, 1'b0);
        pin(3'h2, 2'h1, 3'h2, 1'b0, 1'b1);
        pin(3'h1, 2'h0, 3'h4, 1'b0, 1'b1);
        pin(3'h1, 2'h3, 3'h4, 1'b0, 1'b1);
        rchk(8'h1F, 8'h07);
        end_sim();
    end
endmodule : otp_config_flush_status_pin_test

`default_nettype wire
